// ---- include/output_driver_format_pkg.sv ----
// Purpose: constants and types for the output driver format registers
// Assumes: AXI4-Lite word access, control bytes sit in byte lane 0
// Notes:   byte address of a register is four times its index
package output_driver_format_pkg;

  //////////////////////////////////////////////////////////////////////
  // bus
  localparam int         ADDR_W      = 12;
  localparam int         DATA_W      = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [7:0] CH2_CTL_IDX = 8'h22;
  localparam logic [7:0] CH3_CTL_IDX = 8'h23;
  localparam logic [7:0] STATUS_IDX  = 8'h40;

  //////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FMT_LSB    = 5;
  localparam int SET_A_LSB  = 3;
  localparam int SET_B_LSB  = 1;
  localparam int RSV_HI_BIT = 7;
  localparam int ST_CH2_ON  = 0;
  localparam int ST_CH3_ON  = 1;
  localparam int ST_CH2_RSV = 2;

  //////////////////////////////////////////////////////////////////////
  // reset values and write masks
  localparam logic [1:0] FMT_RST     = 2'h1;
  localparam logic [1:0] SET_A_RST   = 2'h2;
  localparam logic [1:0] SET_B_RST   = 2'h0;
  localparam logic [7:0] CH2_RESET   = {1'h1, FMT_RST, SET_A_RST, SET_B_RST, 1'h0};
  localparam logic [7:0] CH3_RESET   = {1'h0, FMT_RST, SET_A_RST, SET_B_RST, 1'h0};
  localparam logic [7:0] CH2_WR_MASK = 8'hFE;
  localparam logic [7:0] CH3_WR_MASK = 8'h7E;

  //////////////////////////////////////////////////////////////////////
  // tail current in mA, load in ohm
  localparam logic [4:0] TAIL_NONE  = 5'h00;
  localparam logic [4:0] TAIL_4MA   = 5'h04;
  localparam logic [4:0] TAIL_6MA   = 5'h06;
  localparam logic [4:0] TAIL_8MA   = 5'h08;
  localparam logic [4:0] TAIL_16MA  = 5'h10;
  localparam logic [7:0] LOAD_NONE  = 8'h00;
  localparam logic [7:0] LOAD_50    = 8'h32;
  localparam logic [7:0] LOAD_100   = 8'h64;
  localparam logic [7:0] LOAD_200   = 8'hC8;

  //////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    FMT_OFF     = 2'h0,
    FMT_AC_DIFF = 2'h1,
    FMT_HCSL    = 2'h2,
    FMT_CMOS    = 2'h3
  } drv_fmt_t;

  typedef enum logic [1:0] {
    LEG_OFF_Z   = 2'h0,
    LEG_OFF_LOW = 2'h1,
    LEG_ON_INV  = 2'h2,
    LEG_ON_NORM = 2'h3
  } leg_t;

  typedef enum logic {WS_COLLECT = 1'h0, WS_RESP = 1'h1} wr_state_t;
  typedef enum logic {RS_IDLE = 1'h0, RS_RESP = 1'h1} rd_state_t;

  // word address matches a register index
  function automatic logic word_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
    return addr[ADDR_W-1:2] == {2'h0, idx};
  endfunction

endpackage

// ---- include/chan_reg_if.sv ----
// Purpose: carrier between the bus slave and one channel control register
// Assumes: one clock domain
// Notes:   wr_en is a one-cycle strobe
interface chan_reg_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  modport bus_side (output wr_en, output wr_data, input value);
  modport reg_side (input wr_en, input wr_data, output value);
endinterface

// ---- rtl/chan_ctl_reg.sv ----
// Purpose: one 8-bit channel output control register
// Assumes: writes arrive as single-cycle strobes
// Notes:   bits outside the write mask stay zero
module chan_ctl_reg
  import output_driver_format_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF
) (
  // clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    rst_i,
  input  wire logic    ce_i,
  // register access
  chan_reg_if.reg_side bus
);

  logic [7:0] ctl_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg <= RESET_VAL;
    end else if (ce_i && bus.wr_en) begin
      ctl_reg <= bus.wr_data & WR_MASK;
    end
  end

  assign bus.value = ctl_reg;

endmodule

// ---- rtl/drv_fmt_decode.sv ----
// Purpose: decode a channel control byte into driver settings
// Assumes: control byte already masked
// Notes:   purely combinational
module drv_fmt_decode
  import output_driver_format_pkg::*;
(
  // control byte
  input  wire logic [7:0] ctl_i,
  // decoded driver settings
  output drv_fmt_t        format_o,
  output logic [4:0]      tail_ma_o,
  output logic [7:0]      load_ohm_o,
  output logic            load_z_o,
  output leg_t            true_leg_o,
  output leg_t            comp_leg_o,
  output logic            active_o
);

  logic [1:0] set_a;
  logic [1:0] set_b;
  logic       diff;

  assign format_o = drv_fmt_t'(ctl_i[FMT_LSB +: 2]);
  assign set_a    = ctl_i[SET_A_LSB +: 2];
  assign set_b    = ctl_i[SET_B_LSB +: 2];
  assign diff     = (format_o == FMT_AC_DIFF) || (format_o == FMT_HCSL);

  // tail current in differential formats
  always_comb begin
    tail_ma_o = TAIL_NONE;
    if (diff) begin
      case (set_a)
        2'h0:    tail_ma_o = TAIL_4MA;
        2'h1:    tail_ma_o = TAIL_6MA;
        2'h2:    tail_ma_o = TAIL_8MA;
        default: tail_ma_o = (format_o == FMT_HCSL) ? TAIL_16MA : TAIL_8MA;
      endcase
    end
  end

  // hcsl load
  always_comb begin
    load_ohm_o = LOAD_NONE;
    if (format_o == FMT_HCSL) begin
      case (set_b)
        2'h1:    load_ohm_o = LOAD_50;
        2'h2:    load_ohm_o = LOAD_100;
        2'h3:    load_ohm_o = LOAD_200;
        default: load_ohm_o = LOAD_NONE;
      endcase
    end
  end

  assign load_z_o   = (format_o == FMT_HCSL) && (set_b == 2'h0);
  assign true_leg_o = (format_o == FMT_CMOS) ? leg_t'(set_a) : LEG_OFF_Z;
  assign comp_leg_o = (format_o == FMT_CMOS) ? leg_t'(set_b) : LEG_OFF_Z;
  assign active_o   = diff || ((format_o == FMT_CMOS) && (set_a[1] || set_b[1]));

endmodule

// ---- rtl/output_driver_format_ctl.sv ----
// Purpose: channel 2 and 3 output driver format registers on AXI4-Lite
// Assumes: 40 MHz clk_sys_i, single outstanding write and read
// Notes:   control bytes in lane 0, upper read bits are zero
//
// Added by the designer: the AXI4-Lite register port.
module output_driver_format_ctl
  import output_driver_format_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // axi4-lite write address
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  // axi4-lite write data
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [3:0]        wstrb_i,
  // axi4-lite write response
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  output logic [1:0]             bresp_o,
  // axi4-lite read address
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  input  wire logic [ADDR_W-1:0] araddr_i,
  // axi4-lite read data
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  // channel 2 driver
  output logic [7:0]             ch2_ctl_o,
  output drv_fmt_t               ch2_format_o,
  output logic [4:0]             ch2_tail_ma_o,
  output logic [7:0]             ch2_load_ohm_o,
  output logic                   ch2_load_z_o,
  output leg_t                   ch2_true_leg_o,
  output leg_t                   ch2_comp_leg_o,
  output logic                   ch2_active_o,
  // channel 3 driver
  output logic [7:0]             ch3_ctl_o,
  output drv_fmt_t               ch3_format_o,
  output logic [4:0]             ch3_tail_ma_o,
  output logic [7:0]             ch3_load_ohm_o,
  output logic                   ch3_load_z_o,
  output leg_t                   ch3_true_leg_o,
  output leg_t                   ch3_comp_leg_o,
  output logic                   ch3_active_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  wr_state_t         wr_state_reg;
  rd_state_t         rd_state_reg;
  logic              aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_held_reg;
  logic [7:0]        w_data_reg;
  logic              w_lane0_reg;
  logic [1:0]        bresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0]        rresp_reg;
  logic [DATA_W-1:0] rd_word;
  logic              rd_err;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_go;
  logic              wr_hit_ch2;
  logic              wr_hit_ch3;
  logic              wr_hit_st;
  logic [2:0]        status_reg;

  drv_fmt_t          ch2_fmt;
  logic [4:0]        ch2_tail;
  logic [7:0]        ch2_load;
  logic              ch2_lz;
  leg_t              ch2_tleg;
  leg_t              ch2_cleg;
  logic              ch2_act;
  drv_fmt_t          ch3_fmt;
  logic [4:0]        ch3_tail;
  logic [7:0]        ch3_load;
  logic              ch3_lz;
  leg_t              ch3_tleg;
  leg_t              ch3_cleg;
  logic              ch3_act;

  chan_reg_if ch2_bus ();
  chan_reg_if ch3_bus ();

  ////////////////////////////////////////////////////////////////////////
  // handshakes
  assign awready_o = ce_i && !aw_held_reg && (wr_state_reg == WS_COLLECT);
  assign wready_o  = ce_i && !w_held_reg && (wr_state_reg == WS_COLLECT);
  assign arready_o = ce_i && (rd_state_reg == RS_IDLE);
  assign bvalid_o  = (wr_state_reg == WS_RESP);
  assign rvalid_o  = (rd_state_reg == RS_RESP);
  assign bresp_o   = bresp_reg;
  assign rdata_o   = rdata_reg;
  assign rresp_o   = rresp_reg;

  assign aw_take = awvalid_i && awready_o;
  assign w_take  = wvalid_i && wready_o;
  assign ar_take = arvalid_i && arready_o;
  assign wr_go   = ce_i && aw_held_reg && w_held_reg && (wr_state_reg == WS_COLLECT);

  ////////////////////////////////////////////////////////////////////////
  // write address and data capture, either order
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_reg <= 1'h0;
      aw_addr_reg <= '0;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_held_reg <= 1'h1;
        aw_addr_reg <= awaddr_i;
      end else if (wr_go) begin
        aw_held_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      w_held_reg  <= 1'h0;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'h0;
    end else if (ce_i) begin
      if (w_take) begin
        w_held_reg  <= 1'h1;
        w_data_reg  <= wdata_i[7:0];
        w_lane0_reg <= wstrb_i[0];
      end else if (wr_go) begin
        w_held_reg <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write decode and response
  assign wr_hit_ch2 = word_hit(aw_addr_reg, CH2_CTL_IDX);
  assign wr_hit_ch3 = word_hit(aw_addr_reg, CH3_CTL_IDX);
  assign wr_hit_st  = word_hit(aw_addr_reg, STATUS_IDX);

  assign ch2_bus.wr_en   = wr_go && w_lane0_reg && wr_hit_ch2;
  assign ch2_bus.wr_data = w_data_reg;
  assign ch3_bus.wr_en   = wr_go && w_lane0_reg && wr_hit_ch3;
  assign ch3_bus.wr_data = w_data_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_state_reg <= WS_COLLECT;
      bresp_reg    <= RESP_OKAY;
    end else if (ce_i) begin
      case (wr_state_reg)
        WS_COLLECT: begin
          if (wr_go) begin
            wr_state_reg <= WS_RESP;
            bresp_reg    <= (wr_hit_ch2 || wr_hit_ch3 || wr_hit_st) ? RESP_OKAY
                                                                    : RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (bready_i) begin
            wr_state_reg <= WS_COLLECT;
          end
        end
        default: begin
          wr_state_reg <= WS_COLLECT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode
  always_comb begin
    rd_word = '0;
    rd_err  = 1'h0;
    if (word_hit(araddr_i, CH2_CTL_IDX)) begin
      rd_word[7:0] = ch2_bus.value;
    end else if (word_hit(araddr_i, CH3_CTL_IDX)) begin
      rd_word[7:0] = ch3_bus.value;
    end else if (word_hit(araddr_i, STATUS_IDX)) begin
      rd_word[2:0] = status_reg;
    end else begin
      rd_err = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state_reg <= RS_IDLE;
      rdata_reg    <= '0;
      rresp_reg    <= RESP_OKAY;
    end else if (ce_i) begin
      case (rd_state_reg)
        RS_IDLE: begin
          if (ar_take) begin
            rd_state_reg <= RS_RESP;
            rdata_reg    <= rd_word;
            rresp_reg    <= rd_err ? RESP_SLVERR : RESP_OKAY;
          end
        end
        RS_RESP: begin
          if (rready_i) begin
            rd_state_reg <= RS_IDLE;
          end
        end
        default: begin
          rd_state_reg <= RS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel control registers
  chan_ctl_reg #(
    .RESET_VAL (CH2_RESET),
    .WR_MASK   (CH2_WR_MASK)
  ) u_ch2_reg (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .bus       (ch2_bus)
  );

  chan_ctl_reg #(
    .RESET_VAL (CH3_RESET),
    .WR_MASK   (CH3_WR_MASK)
  ) u_ch3_reg (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .bus       (ch3_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // driver setting decode
  drv_fmt_decode u_ch2_dec (
    .ctl_i      (ch2_bus.value),
    .format_o   (ch2_fmt),
    .tail_ma_o  (ch2_tail),
    .load_ohm_o (ch2_load),
    .load_z_o   (ch2_lz),
    .true_leg_o (ch2_tleg),
    .comp_leg_o (ch2_cleg),
    .active_o   (ch2_act)
  );

  drv_fmt_decode u_ch3_dec (
    .ctl_i      (ch3_bus.value),
    .format_o   (ch3_fmt),
    .tail_ma_o  (ch3_tail),
    .load_ohm_o (ch3_load),
    .load_z_o   (ch3_lz),
    .true_leg_o (ch3_tleg),
    .comp_leg_o (ch3_cleg),
    .active_o   (ch3_act)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel 2 driver outputs
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ch2_ctl_o      <= CH2_RESET;
      ch2_format_o   <= drv_fmt_t'(FMT_RST);
      ch2_tail_ma_o  <= TAIL_8MA;
      ch2_load_ohm_o <= LOAD_NONE;
      ch2_load_z_o   <= 1'h0;
      ch2_true_leg_o <= LEG_OFF_Z;
      ch2_comp_leg_o <= LEG_OFF_Z;
      ch2_active_o   <= 1'h1;
    end else if (ce_i) begin
      ch2_ctl_o      <= ch2_bus.value;
      ch2_format_o   <= ch2_fmt;
      ch2_tail_ma_o  <= ch2_tail;
      ch2_load_ohm_o <= ch2_load;
      ch2_load_z_o   <= ch2_lz;
      ch2_true_leg_o <= ch2_tleg;
      ch2_comp_leg_o <= ch2_cleg;
      ch2_active_o   <= ch2_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel 3 driver outputs
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ch3_ctl_o      <= CH3_RESET;
      ch3_format_o   <= drv_fmt_t'(FMT_RST);
      ch3_tail_ma_o  <= TAIL_8MA;
      ch3_load_ohm_o <= LOAD_NONE;
      ch3_load_z_o   <= 1'h0;
      ch3_true_leg_o <= LEG_OFF_Z;
      ch3_comp_leg_o <= LEG_OFF_Z;
      ch3_active_o   <= 1'h1;
    end else if (ce_i) begin
      ch3_ctl_o      <= ch3_bus.value;
      ch3_format_o   <= ch3_fmt;
      ch3_tail_ma_o  <= ch3_tail;
      ch3_load_ohm_o <= ch3_load;
      ch3_load_z_o   <= ch3_lz;
      ch3_true_leg_o <= ch3_tleg;
      ch3_comp_leg_o <= ch3_cleg;
      ch3_active_o   <= ch3_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status: live driver state, read only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= 3'h0;
    end else if (ce_i) begin
      status_reg[ST_CH2_ON]  <= ch2_act;
      status_reg[ST_CH3_ON]  <= ch3_act;
      status_reg[ST_CH2_RSV] <= ch2_bus.value[RSV_HI_BIT];
    end
  end

endmodule

// ---- tb/output_driver_format_ctl_monitor.sv ----
// Purpose: concurrent checks on the output driver format register block
// Assumes: one clock domain, reset active high
// Notes:   watches top-level ports only
module output_driver_format_ctl_monitor
  import output_driver_format_pkg::*;
(
  // clock, reset, enable
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  // register bus
  input wire logic              awvalid_i,
  input wire logic              awready_o,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic              wvalid_i,
  input wire logic              wready_o,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [3:0]        wstrb_i,
  input wire logic              bvalid_o,
  input wire logic              bready_i,
  input wire logic [1:0]        bresp_o,
  input wire logic              arvalid_i,
  input wire logic              arready_o,
  input wire logic              rvalid_o,
  input wire logic              rready_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // channel outputs
  input wire logic [7:0]        ch2_ctl_o,
  input drv_fmt_t               ch2_format_o,
  input wire logic [4:0]        ch2_tail_ma_o,
  input wire logic [7:0]        ch2_load_ohm_o,
  input wire logic              ch2_load_z_o,
  input leg_t                   ch2_true_leg_o,
  input leg_t                   ch2_comp_leg_o,
  input wire logic [7:0]        ch3_ctl_o,
  input drv_fmt_t               ch3_format_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] TAILS [4] = '{5'h04, 5'h06, 5'h08, 5'h10};
  localparam logic [7:0] LOADS [4] = '{8'h00, 8'h32, 8'h64, 8'hC8};
  logic [1:0] fmt;
  assign fmt = ch2_ctl_o[6:5];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  //////////////////////////////////////////////////////////////////////
  sequence s_take(a);
    awvalid_i && awready_o && wvalid_i && wready_o && awaddr_i == a && wstrb_i[0];
  endsequence
  sequence s_run;
    ce_i [*2];
  endsequence

  property p_fmt;
    ch2_format_o == fmt && ch3_format_o == ch3_ctl_o[6:5];
  endproperty
  property p_tail;
    ch2_tail_ma_o == ((fmt == 2'h1 && ch2_ctl_o[4:3] == 2'h3) ? 5'h08 :
      (fmt inside {2'h1, 2'h2}) ? TAILS[ch2_ctl_o[4:3]] : 5'h00);
  endproperty
  property p_legs;
    ch2_true_leg_o == (fmt == 2'h3 ? ch2_ctl_o[4:3] : 2'h0) &&
    ch2_comp_leg_o == (fmt == 2'h3 ? ch2_ctl_o[2:1] : 2'h0);
  endproperty
  property p_load;
    ch2_load_ohm_o == (fmt == 2'h2 ? LOADS[ch2_ctl_o[2:1]] : 8'h00) &&
    ch2_load_z_o == (fmt == 2'h2 && ch2_ctl_o[2:1] == 2'h0);
  endproperty
  property p_rst;
    $fell(rst_i) |-> ch2_ctl_o == 8'hB0 && ch3_ctl_o == 8'h30;
  endproperty
  property p_rsv;
    !ch2_ctl_o[0] && !ch3_ctl_o[0] && !ch3_ctl_o[7];
  endproperty
  property p_wr2;
    s_take(12'h088) ##1 s_run |=> ch2_ctl_o == ($past(wdata_i[7:0], 3) & 8'hFE);
  endproperty
  property p_wr3;
    s_take(12'h08C) ##1 s_run |=> ch3_ctl_o == ($past(wdata_i[7:0], 3) & 8'h7E);
  endproperty
  property p_wresp;
    awvalid_i && awready_o && wvalid_i && wready_o ##1 ce_i |=> bvalid_o;
  endproperty
  property p_bhold;
    bvalid_o && !(bready_i && ce_i) |=> bvalid_o && $stable(bresp_o);
  endproperty
  property p_rhold;
    rvalid_o && !(rready_i && ce_i) |=> rvalid_o && $stable(rdata_o);
  endproperty
  property p_rd;
    arvalid_i && arready_o |=> rvalid_o;
  endproperty

  a_fmt: assert property (p_fmt) else $error("format output mismatch");
  a_tail: assert property (p_tail) else $error("tail current mismatch");
  a_legs: assert property (p_legs) else $error("cmos leg mismatch");
  a_load: assert property (p_load) else $error("hcsl load mismatch");
  a_rst: assert property (p_rst) else $error("reset value mismatch");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_wr2: assert property (p_wr2) else $error("ch2 write not stored");
  a_wr3: assert property (p_wr3) else $error("ch3 write not stored");
  a_wresp: assert property (p_wresp) else $error("write response late");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_rd: assert property (p_rd) else $error("read data late");
endmodule

bind output_driver_format_ctl output_driver_format_ctl_monitor output_driver_format_ctl_monitor_i (
  .clk_sys_i, .rst_i, .ce_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o,
  .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .rvalid_o,
  .rready_i, .rdata_o, .ch2_ctl_o, .ch2_format_o, .ch2_tail_ma_o, .ch2_load_ohm_o,
  .ch2_load_z_o, .ch2_true_leg_o, .ch2_comp_leg_o, .ch3_ctl_o, .ch3_format_o
);

// ---- tb/test_output_driver_format_ctl.sv ----
// Purpose: self-checking bench for the output driver format registers
// Assumes: 40 MHz clock, aligned word accesses
// Notes:   reset check first, then table rows, then hand-written cases
module test_output_driver_format_ctl
  import output_driver_format_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [4:0]  tail;
    logic [7:0]  load;
    logic [3:0]  legs;
  } row_t;
  localparam row_t ROWS [11] = '{
    '{12'h088, 8'hFF, 8'hFE, 5'h00, 8'h00, 4'hF}, '{12'h088, 8'h5E, 8'h5E, 5'h10, 8'hC8, 4'h0},
    '{12'h088, 8'h41, 8'h40, 5'h04, 8'h00, 4'h0}, '{12'h088, 8'h4A, 8'h4A, 5'h06, 8'h32, 4'h0},
    '{12'h088, 8'h54, 8'h54, 5'h08, 8'h64, 4'h0}, '{12'h088, 8'h38, 8'h38, 5'h08, 8'h00, 4'h0},
    '{12'h088, 8'h00, 8'h00, 5'h00, 8'h00, 4'h0}, '{12'h08C, 8'hFF, 8'h7E, 5'h00, 8'h00, 4'hF},
    '{12'h08C, 8'h6C, 8'h6C, 5'h00, 8'h00, 4'h6}, '{12'h08C, 8'h20, 8'h20, 5'h04, 8'h00, 4'h0},
    '{12'h08C, 8'hA2, 8'h22, 5'h04, 8'h00, 4'h0}};

  logic              clk_sys_i, rst_i, ce_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic              awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic              ch2_load_z_o, ch3_load_z_o, ch2_active_o, ch3_active_o;
  logic [ADDR_W-1:0] awaddr_i, araddr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, d;
  logic [3:0]        wstrb_i;
  logic [1:0]        bresp_o, rresp_o;
  logic [7:0]        ch2_ctl_o, ch3_ctl_o, ch2_load_ohm_o, ch3_load_ohm_o;
  logic [4:0]        ch2_tail_ma_o, ch3_tail_ma_o;
  drv_fmt_t          ch2_format_o, ch3_format_o;
  leg_t              ch2_true_leg_o, ch2_comp_leg_o, ch3_true_leg_o, ch3_comp_leg_o;
  logic              sel, exp_z, exp_on;
  int                mismatches, comparisons, cycles;

  output_driver_format_ctl output_driver_format_ctl_i (
    .clk_sys_i, .rst_i, .ce_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o,
    .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i,
    .rvalid_o, .rready_i, .rdata_o, .rresp_o, .ch2_ctl_o, .ch2_format_o, .ch2_tail_ma_o,
    .ch2_load_ohm_o, .ch2_load_z_o, .ch2_true_leg_o, .ch2_comp_leg_o, .ch2_active_o,
    .ch3_ctl_o, .ch3_format_o, .ch3_tail_ma_o, .ch3_load_ohm_o, .ch3_load_z_o,
    .ch3_true_leg_o, .ch3_comp_leg_o, .ch3_active_o);

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] v, input logic s,
                        input logic [1:0] er);
    @(posedge clk_sys_i);
    awvalid_i <= 1'b1;
    awaddr_i <= a;
    wvalid_i <= 1'b1;
    wdata_i <= {24'h000000, v};
    wstrb_i <= {3'h0, s};
    bready_i <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o && ce_i) begin
        chk_resp("bresp", er, bresp_o);
        bready_i <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] q);
    @(posedge clk_sys_i);
    arvalid_i <= 1'b1;
    araddr_i <= a;
    rready_i <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o && ce_i) begin
        q = rdata_o;
        chk_resp("rresp", er, rresp_o);
        rready_i <= 1'b0;
        break;
      end
    end
  endtask

  task automatic chk_reset;
    logic [31:0] q;
    axi_rd(12'h088, RESP_OKAY, q);
    chk("ch2 reset", 32'h000000B0, q);
    axi_rd(12'h08C, RESP_OKAY, q);
    chk("ch3 reset", 32'h00000030, q);
    chk("ch2 tail reset", 32'h00000008, 32'(ch2_tail_ma_o));
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, ce_i} = 2'h3;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h00;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = '0;
    {mismatches, comparisons, cycles} = '0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk_reset();
    foreach (ROWS[i]) begin
      axi_wr(ROWS[i].a, ROWS[i].wd, 1'b1, RESP_OKAY);
      axi_rd(ROWS[i].a, RESP_OKAY, d);
      sel = ROWS[i].a[2];
      chk("readback", 32'(ROWS[i].rd), d);
      chk("format", 32'(ROWS[i].wd[6:5]), 32'(sel ? ch3_format_o : ch2_format_o));
      chk("tail", 32'(ROWS[i].tail), 32'(sel ? ch3_tail_ma_o : ch2_tail_ma_o));
      chk("load", 32'(ROWS[i].load), 32'(sel ? ch3_load_ohm_o : ch2_load_ohm_o));
      chk("legs", 32'(ROWS[i].legs), sel ? 32'({ch3_true_leg_o, ch3_comp_leg_o}) :
          32'({ch2_true_leg_o, ch2_comp_leg_o}));
      exp_z  = ROWS[i].wd[6:5] == FMT_HCSL && ROWS[i].load == 8'h00;
      exp_on = ROWS[i].tail != 5'h00 || ROWS[i].legs[3] || ROWS[i].legs[1];
      chk("load z", 32'(exp_z), 32'(sel ? ch3_load_z_o : ch2_load_z_o));
      chk("active", 32'(exp_on), 32'(sel ? ch3_active_o : ch2_active_o));
    end
    // enable low stalls a write and then its response
    ce_i <= 1'b0;
    fork
      axi_wr(12'h08C, 8'h4A, 1'b1, RESP_OKAY);
      begin
        repeat (4) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        ce_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        ce_i <= 1'b1;
      end
    join
    @(posedge clk_sys_i);
    chk("stalled write", 32'h0000004A, 32'(ch3_ctl_o));
    chk("ch3 hcsl load", 32'h00000032, 32'(ch3_load_ohm_o));
    // strobe off, unmapped and status writes store nothing
    axi_wr(12'h08C, 8'h00, 1'b0, RESP_OKAY);
    axi_wr(12'h090, 8'h00, 1'b1, RESP_SLVERR);
    axi_wr(12'h100, 8'h00, 1'b1, RESP_OKAY);
    axi_rd(12'h08C, RESP_OKAY, d);
    chk("no store", 32'h0000004A, d);
    // enable low stalls a read response
    fork
      axi_rd(12'h100, RESP_OKAY, d);
      begin
        repeat (2) @(posedge clk_sys_i);
        ce_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        ce_i <= 1'b1;
      end
    join
    chk("stalled status read", 32'h00000002, d);
    axi_rd(12'hFFC, RESP_SLVERR, d);
    // reset in mid-run
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk_reset();
    close_out();
  end
endmodule
